// ---- core/gpcfg_top.v ----
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "gpcfg_map.vh"

// Overview of operation
// - Alt bit 0: GPIO, direction bit rules
// - Alt bit 1: peripheral owns the pin
// - Open-drain bank reached under selector 03H
// - Open-drain bit 1 blocks high drive
// - Open-drain bit 0 drives both levels
// - Open-drain applies under alternate function too
// - Drive-strength bank reached under selector 04H
// - Drive bit picks standard or high current
// - Drive strength applies under alternate function
// - Wake bank reached under selector 05H
// - Enabled pin transition in stop wakes
// - Disabled pin transitions never wake
// - Selector 00H and 06H-FFH map nothing
// - Direction 0 drives, 1 tri-states and samples
module gpcfg_top #(
	parameter PORTS = 8,
	parameter PINS  = 8
) (
	input  wire                      clock,
	input  wire                      rst_n,
	input  wire [`GPCFG_ADDR_W-1:0]  reg_addr,
	input  wire [7:0]                reg_wdata,
	input  wire                      reg_wr,
	input  wire                      reg_rd,
	output reg  [7:0]                reg_rdata,
	input  wire                      stop_mode,
	input  wire [PORTS*PINS-1:0]     gpio_data,
	input  wire [PORTS*PINS-1:0]     alt_out,
	input  wire [PORTS*PINS-1:0]     alt_oe,
	input  wire [PORTS*PINS-1:0]     pad_in,
	output wire [PORTS*PINS-1:0]     pad_out,
	output wire [PORTS*PINS-1:0]     pad_oe,
	output wire [PORTS*PINS-1:0]     pad_high_drive,
	output reg  [PORTS*PINS-1:0]     pin_in_data,
	output wire                      stop_recover,
	output reg                       irq
);

	localparam N = PORTS * PINS;

	// ********************************************************
	// Flat views of the per-port banks
	// ********************************************************
	wire [N-1:0]       dir_flat;
	wire [N-1:0]       alt_flat;
	wire [N-1:0]       od_flat;
	wire [N-1:0]       hd_flat;
	wire [N-1:0]       wake_flat;
	wire [N-1:0]       pin_event;
	wire [PORTS-1:0]   port_event;
	wire [PORTS*8-1:0] sel_flat;
	wire [PORTS*8-1:0] win_flat;

	reg  [7:0]         status;
	reg  [7:0]         mask;
	reg  [7:0]         next_rdata;
	reg  [7:0]         next_status;

	wire               pair_hit;
	wire [2:0]         pair_port;
	wire               win_access;

	// Selector/window pairs sit in the low half of the map
	assign pair_hit   = ~reg_addr[`GPCFG_ADDR_PAIR_BIT];
	assign pair_port  = reg_addr[`GPCFG_ADDR_PORT_MSB:`GPCFG_ADDR_PORT_LSB];
	assign win_access = reg_addr[`GPCFG_ADDR_WIN_BIT];

	// ********************************************************
	// Per-port configuration banks
	// ********************************************************
	genvar p;
	generate
		for (p = 0; p < PORTS; p = p + 1) begin : g_port
			reg  [7:0] sel;
			reg  [7:0] dir;
			reg  [7:0] alt;
			reg  [7:0] od;
			reg  [7:0] hd;
			reg  [7:0] wake;
			reg  [7:0] win_view;
			wire       hit_sel;
			wire       hit_win;

			// Each port decodes its own pair, so banks never alias
			assign hit_sel = pair_hit & (pair_port == p) & ~win_access;
			assign hit_win = pair_hit & (pair_port == p) & win_access;

			// Selector steers which bank the window shows
			always @* begin
				case (sel)
					`GPCFG_SEL_DIR:  win_view = dir;
					`GPCFG_SEL_ALT:  win_view = alt;
					`GPCFG_SEL_OD:   win_view = od;
					`GPCFG_SEL_HD:   win_view = hd;
					`GPCFG_SEL_WAKE: win_view = wake;
					default:         win_view = `GPCFG_RD_ZERO;
				endcase
			end

			// Window writes land only in the bank the selector names;
			// an unmapped code swallows them, guarding against stray writes
			always @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					sel  <= `GPCFG_RST_SEL;
					dir  <= `GPCFG_RST_DIR;
					alt  <= `GPCFG_RST_BANK;
					od   <= `GPCFG_RST_BANK;
					hd   <= `GPCFG_RST_BANK;
					wake <= `GPCFG_RST_BANK;
				end else if (reg_wr & hit_sel) begin
					sel <= reg_wdata;
				end else if (reg_wr & hit_win) begin
					case (sel)
						`GPCFG_SEL_DIR:  dir  <= reg_wdata;
						`GPCFG_SEL_ALT:  alt  <= reg_wdata;
						`GPCFG_SEL_OD:   od   <= reg_wdata;
						`GPCFG_SEL_HD:   hd   <= reg_wdata;
						`GPCFG_SEL_WAKE: wake <= reg_wdata;
						default:         sel  <= sel;
					endcase
				end
			end

			assign dir_flat[p*PINS +: PINS]  = dir[PINS-1:0];
			assign alt_flat[p*PINS +: PINS]  = alt[PINS-1:0];
			assign od_flat[p*PINS +: PINS]   = od[PINS-1:0];
			assign hd_flat[p*PINS +: PINS]   = hd[PINS-1:0];
			assign wake_flat[p*PINS +: PINS] = wake[PINS-1:0];
			assign sel_flat[p*8 +: 8]        = sel;
			assign win_flat[p*8 +: 8]        = win_view;
			assign port_event[p]             = |pin_event[p*PINS +: PINS];
		end
	endgenerate

	// ********************************************************
	// Pin output stage
	// ********************************************************
	gpcfg_pin_drive #(
		.W(N)
	) u_drive (
		.clock          (clock),
		.rst_n          (rst_n),
		.dir            (dir_flat),
		.alt            (alt_flat),
		.od             (od_flat),
		.hd             (hd_flat),
		.gpio_data      (gpio_data),
		.alt_out        (alt_out),
		.alt_oe         (alt_oe),
		.pad_out        (pad_out),
		.pad_oe         (pad_oe),
		.pad_high_drive (pad_high_drive)
	);

	// Pins are sampled only while set as GPIO inputs; outputs and alternate-function pins read 0
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pin_in_data <= {N{1'b0}};
		end else begin
			pin_in_data <= pad_in & dir_flat & ~alt_flat;
		end
	end

	// ********************************************************
	// Stop-mode wake detection
	// ********************************************************
	gpcfg_wake_detect #(
		.W(N)
	) u_wake (
		.clock     (clock),
		.rst_n     (rst_n),
		.stop_mode (stop_mode),
		.wake_en   (wake_flat),
		.pad_in    (pad_in),
		.pin_event (pin_event),
		.wake_req  (stop_recover)
	);

	// ********************************************************
	// Wake status, mask and interrupt
	// ********************************************************

	// A wake that lands in the clearing read survives: set wins
	always @* begin
		next_status = status;
		if (reg_rd & (reg_addr == `GPCFG_ADDR_STATUS)) begin
			next_status = `GPCFG_RST_STATUS;
		end
		next_status = next_status | port_event[7:0];
	end

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			status <= `GPCFG_RST_STATUS;
			mask   <= `GPCFG_RST_MASK;
			irq    <= 1'b0;
		end else begin
			status <= next_status;
			if (reg_wr & (reg_addr == `GPCFG_ADDR_MASK)) begin
				mask <= reg_wdata;
			end
			irq <= |(next_status & mask);
		end
	end

	// ********************************************************
	// Read path, data one cycle after the strobe
	// ********************************************************
	always @* begin
		next_rdata = `GPCFG_RD_ZERO;
		if (pair_hit) begin
			if (win_access) begin
				next_rdata = win_flat[pair_port*8 +: 8];
			end else begin
				next_rdata = sel_flat[pair_port*8 +: 8];
			end
		end else begin
			case (reg_addr)
				`GPCFG_ADDR_STATUS: next_rdata = status;
				`GPCFG_ADDR_MASK:   next_rdata = mask;
				`GPCFG_ADDR_INDATA: next_rdata = {7'h00, stop_mode};
				default:            next_rdata = `GPCFG_RD_ZERO;
			endcase
		end
	end

	// Data stand for exactly the cycle after the read strobe
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= `GPCFG_RD_ZERO;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end else begin
			reg_rdata <= `GPCFG_RD_ZERO;
		end
	end

endmodule // gpcfg_top

// ---- core/gpcfg_map.vh ----
`ifndef GPCFG_MAP_VH
`define GPCFG_MAP_VH

// ********************************************************
// Selector codes seen through a port window
// ********************************************************
`define GPCFG_SEL_NONE      8'h00
`define GPCFG_SEL_DIR       8'h01
`define GPCFG_SEL_ALT       8'h02
`define GPCFG_SEL_OD        8'h03
`define GPCFG_SEL_HD        8'h04
`define GPCFG_SEL_WAKE      8'h05

// ********************************************************
// Register map of the plain register port
// ********************************************************
`define GPCFG_ADDR_W        5
// Port p selector at {0,p,0}, window at {0,p,1}
`define GPCFG_ADDR_PAIR_BIT 4
`define GPCFG_ADDR_WIN_BIT  0
`define GPCFG_ADDR_PORT_LSB 1
`define GPCFG_ADDR_PORT_MSB 3
`define GPCFG_ADDR_STATUS   5'h10
`define GPCFG_ADDR_MASK     5'h11
`define GPCFG_ADDR_INDATA   5'h12

// ********************************************************
// Reset values
// ********************************************************
`define GPCFG_RST_SEL       8'h00
`define GPCFG_RST_DIR       8'hff
`define GPCFG_RST_BANK      8'h00
`define GPCFG_RST_STATUS    8'h00
`define GPCFG_RST_MASK      8'h00
`define GPCFG_RD_ZERO       8'h00

`endif

// ---- core/gpcfg_pin_drive.v ----
`timescale 1ns/1ps

// ********************************************************
// Registered output stage for a group of pins
// ********************************************************
module gpcfg_pin_drive #(
	parameter W = 64
) (
	input  wire         clock,
	input  wire         rst_n,
	input  wire [W-1:0] dir,
	input  wire [W-1:0] alt,
	input  wire [W-1:0] od,
	input  wire [W-1:0] hd,
	input  wire [W-1:0] gpio_data,
	input  wire [W-1:0] alt_out,
	input  wire [W-1:0] alt_oe,
	output reg  [W-1:0] pad_out,
	output reg  [W-1:0] pad_oe,
	output reg  [W-1:0] pad_high_drive
);

	reg [W-1:0] next_value;
	reg [W-1:0] next_enable;

	// Pick the owner of each pin, then apply the drain setting on top
	always @* begin
		next_value  = (alt & alt_out) | (~alt & gpio_data);
		next_enable = (alt & alt_oe) | (~alt & ~dir);
		// A high level is never pushed while the open-drain bit is set
		next_enable = next_enable & ~(od & next_value);
	end

	// Registered so the pads never see decode glitches
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pad_out        <= {W{1'b0}};
			pad_oe         <= {W{1'b0}};
			pad_high_drive <= {W{1'b0}};
		end else begin
			pad_out        <= next_value;
			pad_oe         <= next_enable;
			pad_high_drive <= hd;
		end
	end

endmodule // gpcfg_pin_drive

// ---- core/gpcfg_wake_detect.v ----
`timescale 1ns/1ps

// ********************************************************
// Transition detector for stop-mode wake sources
// ********************************************************
module gpcfg_wake_detect #(
	parameter W = 64
) (
	input  wire         clock,
	input  wire         rst_n,
	input  wire         stop_mode,
	input  wire [W-1:0] wake_en,
	input  wire [W-1:0] pad_in,
	output reg  [W-1:0] pin_event,
	output reg          wake_req
);

	reg  [W-1:0] last_in;
	reg          armed;
	wire [W-1:0] next_event;

	// Only enabled pins that changed while stopped count; armed skips the
	// first stop cycle so a level left over from run mode is not a change
	assign next_event = (pad_in ^ last_in) & wake_en & {W{stop_mode & armed}};

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			last_in   <= {W{1'b0}};
			armed     <= 1'b0;
			pin_event <= {W{1'b0}};
			wake_req  <= 1'b0;
		end else begin
			last_in   <= pad_in;
			armed     <= stop_mode;
			pin_event <= next_event;
			wake_req  <= |next_event;
		end
	end

endmodule // gpcfg_wake_detect

// ---- sim/gpcfg_monitor.sv ----
`timescale 1ns/1ps
`include "gpcfg_map.vh"

// ********************************************************
// Port-level checks of the pin configuration block
// ********************************************************
module gpcfg_monitor #(
	parameter PORTS = 8,
	parameter PINS  = 8
) (
	input wire                     clock,
	input wire                     rst_n,
	input wire [`GPCFG_ADDR_W-1:0] reg_addr,
	input wire                     reg_rd,
	input wire                     reg_wr,
	input wire [7:0]               reg_rdata,
	input wire                     stop_mode,
	input wire [PORTS*PINS-1:0]    gpio_data,
	input wire [PORTS*PINS-1:0]    alt_out,
	input wire [PORTS*PINS-1:0]    alt_oe,
	input wire [PORTS*PINS-1:0]    pad_in,
	input wire [PORTS*PINS-1:0]    pad_out,
	input wire [PORTS*PINS-1:0]    pad_oe,
	input wire [PORTS*PINS-1:0]    pin_in_data,
	input wire                     stop_recover,
	input wire                     irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// Steps shared by the register and wake checks
	sequence s_rd(a);
		reg_rd && reg_addr == a;
	endsequence
	sequence s_quiet_stop;
		stop_mode ##1 (stop_mode && $stable(pad_in));
	endsequence
	AST_RD_INDATA: assert property (s_rd(`GPCFG_ADDR_INDATA) |=> reg_rdata == {7'h00, $past(stop_mode)})
		else $error("stop flag read back wrong");
	AST_RD_UNMAPPED: assert property (reg_rd && reg_addr > `GPCFG_ADDR_INDATA |=> reg_rdata == 8'h00)
		else $error("unmapped address read not zero");
	AST_PAD_VALUE: assert property (((pad_out ^ $past(gpio_data)) & (pad_out ^ $past(alt_out))) == 0)
		else $error("pad value from neither source");
	AST_GPIO_DRIVE: assert property ((pad_oe & ~$past(alt_oe) & (pad_out ^ $past(gpio_data))) == 0)
		else $error("driven gpio pin shows wrong value");
	AST_INPUT_SAMPLE: assert property ((pin_in_data & (pad_oe | ~$past(pad_in))) == 0)
		else $error("input sample on driven or low pin");
	AST_WAKE_STOP: assert property (!stop_mode |=> !stop_recover ##1 !stop_recover)
		else $error("wake outside stop");
	AST_WAKE_CHANGE: assert property (stop_recover |-> $past(pad_in) != $past(pad_in, 2))
		else $error("wake without pin change");
	AST_WAKE_QUIET: assert property (s_quiet_stop |=> !stop_recover)
		else $error("wake on quiet pins");
	AST_IRQ_FALL: assert property ($fell(irq) |-> $past(reg_rd || reg_wr) || $past(reg_rd || reg_wr, 2))
		else $error("interrupt dropped without access");
endmodule // gpcfg_monitor

bind gpcfg_top gpcfg_monitor #(.PORTS(PORTS), .PINS(PINS)) gpcfg_monitor_inst (.clock(clock), .rst_n(rst_n),
	.reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_rdata(reg_rdata), .stop_mode(stop_mode),
	.gpio_data(gpio_data), .alt_out(alt_out), .alt_oe(alt_oe), .pad_in(pad_in), .pad_out(pad_out),
	.pad_oe(pad_oe), .pin_in_data(pin_in_data), .stop_recover(stop_recover), .irq(irq));

// ---- sim/gpcfg_pins_model.sv ----
`timescale 1ns/1ps

// ********************************************************
// External circuitry on the pins
// ********************************************************
module gpcfg_pins_model #(
	parameter W = 64
) (
	input  wire         clock,
	input  wire [W-1:0] pad_out,
	input  wire [W-1:0] pad_oe,
	input  wire [W-1:0] ext_level,
	output reg  [W-1:0] pad_in
);
	// A released pin shows the outside level, which idles high like a pull-up
	always @(posedge clock) begin
		pad_in <= (pad_oe & pad_out) | (~pad_oe & ext_level);
	end
endmodule // gpcfg_pins_model

// ---- sim/test_gpio_pin_config_subregisters.sv ----
`timescale 1ns/1ps
`include "gpcfg_map.vh"

// ********************************************************
// Self-checking bench
// ********************************************************
module test_gpio_pin_config_subregisters;
	reg         clock = 0;
	reg         rst_n = 0;
	reg  [4:0]  reg_addr = 0;
	reg  [7:0]  reg_wdata = 0;
	reg         reg_wr = 0;
	reg         reg_rd = 0;
	reg         stop_mode = 0;
	reg  [63:0] gpio_data = 0;
	reg  [63:0] alt_out = 0;
	reg  [63:0] alt_oe = 0;
	reg  [63:0] ext_level = {64{1'b1}};
	wire [7:0]  reg_rdata;
	wire [63:0] pad_in, pad_out, pad_oe, pad_high_drive, pin_in_data;
	wire        stop_recover, irq;
	integer     n_mismatch = 0, comparisons = 0, p, k, n;
	reg  [7:0]  bank [0:7][0:5];
	always #5 clock = ~clock;
	gpcfg_top #(.PORTS(8), .PINS(8)) gpcfg_top_inst (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .stop_mode(stop_mode),
		.gpio_data(gpio_data), .alt_out(alt_out), .alt_oe(alt_oe), .pad_in(pad_in), .pad_out(pad_out),
		.pad_oe(pad_oe), .pad_high_drive(pad_high_drive), .pin_in_data(pin_in_data),
		.stop_recover(stop_recover), .irq(irq));
	gpcfg_pins_model #(.W(64)) gpcfg_pins_model_inst (.clock(clock), .pad_out(pad_out), .pad_oe(pad_oe),
		.ext_level(ext_level), .pad_in(pad_in));
	task chk(input [63:0] seen, input [63:0] exp);
		comparisons = comparisons + 1;
		if (seen !== exp) begin
			n_mismatch = n_mismatch + 1;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task summarize;
		$display("counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// Bus cycles: strobes last one cycle, read data looked at only in the following cycle
	task wr(input [4:0] a, input [7:0] d);
		@(posedge clock); reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
		@(posedge clock); reg_wr <= 1'b0;
	endtask
	task rd(input [4:0] a, input [7:0] e);
		@(posedge clock); reg_rd <= 1'b1; reg_addr <= a;
		@(posedge clock); reg_rd <= 1'b0;
		@(negedge clock); chk(reg_rdata, e);
	endtask
	// Window write under a selector code; only mapped codes change the shadow copy
	task sel(input [2:0] pp, input [7:0] c, input [7:0] d);
		wr({1'b0, pp, 1'b0}, c); wr({1'b0, pp, 1'b1}, d);
		if (c >= 1 && c <= 5) bank[pp][c] = d;
	endtask
	task chkwin(input [2:0] pp, input [7:0] c);
		wr({1'b0, pp, 1'b0}, c); rd({1'b0, pp, 1'b1}, (c >= 1 && c <= 5) ? bank[pp][c] : 8'h00);
	endtask
	function [63:0] fold(input integer c);
		integer i;
		for (i = 0; i < 8; i = i + 1) fold[i*8 +: 8] = bank[i][c];
	endfunction
	// Expected pad state worked out from the shadow banks and the inputs
	task pins;
		reg [63:0] dir, alt, od, val;
		repeat (3) @(posedge clock);
		@(negedge clock);
		dir = fold(1); alt = fold(2); od = fold(3);
		val = (alt & alt_out) | (~alt & gpio_data);
		chk(pad_out, val);
		chk(pad_oe, ((alt & alt_oe) | (~alt & ~dir)) & ~(od & val));
		chk(pad_high_drive, fold(4));
		chk(pin_in_data, pad_in & dir & ~alt);
	endtask
	// Counts wake pulses after one pin toggles; the window is fixed so it cannot hang
	task pulse(input integer b, input integer e);
		@(posedge clock); ext_level[b] <= ~ext_level[b];
		n = 0;
		repeat (6) begin @(posedge clock); #1 n = n + stop_recover; end
		chk(64'(n), 64'(e));
	endtask
	initial begin #900000; n_mismatch = n_mismatch + 1; summarize; end
	initial begin
		for (p = 0; p < 8; p = p + 1) for (k = 0; k < 6; k = k + 1) bank[p][k] = (k == 1) ? 8'hff : 8'h00;
		k = $urandom(25102);
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		for (p = 0; p < 8; p = p + 1) begin
			rd({1'b0, p[2:0], 1'b0}, 8'h00);
			for (k = 1; k < 6; k = k + 1) chkwin(p[2:0], k[7:0]);
		end
		$display("test reset values done");
		for (p = 0; p < 8; p = p + 1) begin
			for (k = 1; k < 6; k = k + 1) sel(p[2:0], k[7:0], 8'($urandom));
			sel(p[2:0], 8'h00, 8'($urandom));
			sel(p[2:0], 8'h06 | 8'($urandom), 8'($urandom));
		end
		// Addresses past the map must read zero and leave every bank alone
		wr(5'h13 | 5'($urandom), 8'($urandom));
		rd(5'h13 | 5'($urandom), 8'h00);
		for (p = 0; p < 8; p = p + 1) for (k = 0; k < 7; k = k + 1) chkwin(p[2:0], k[7:0]);
		$display("test bank access done");
		// Corner: every pin open-drain under the peripheral, which drives ones
		for (p = 0; p < 8; p = p + 1) begin sel(p[2:0], 8'h02, 8'hff); sel(p[2:0], 8'h03, 8'hff); end
		@(posedge clock); alt_out <= {64{1'b1}}; alt_oe <= {64{1'b1}};
		pins;
		repeat (30) begin
			sel(3'($urandom), 8'(1 + $urandom % 4), 8'($urandom));
			@(posedge clock);
			gpio_data <= {$urandom, $urandom}; alt_out <= {$urandom, $urandom};
			alt_oe <= {$urandom, $urandom}; ext_level <= {$urandom, $urandom};
			pins;
		end
		$display("test pin control done");
		for (p = 0; p < 8; p = p + 1) begin
			sel(p[2:0], 8'h01, 8'hff); sel(p[2:0], 8'h02, 8'h00); sel(p[2:0], 8'h05, (p == 2) ? 8'h01 : 8'h00);
		end
		@(posedge clock); ext_level <= {64{1'b1}};
		wr(`GPCFG_ADDR_MASK, 8'h00);
		rd(`GPCFG_ADDR_STATUS, 8'h00);
		@(posedge clock); stop_mode <= 1'b1;
		repeat (3) @(posedge clock);
		pulse(16, 1);
		chk(irq, 1'b0);
		pulse(17, 0);
		wr(`GPCFG_ADDR_MASK, 8'hff);
		repeat (2) @(posedge clock);
		@(negedge clock); chk(irq, 1'b1);
		rd(`GPCFG_ADDR_STATUS, 8'h04);
		rd(`GPCFG_ADDR_MASK, 8'hff);
		rd(`GPCFG_ADDR_STATUS, 8'h00);
		repeat (2) @(posedge clock);
		@(negedge clock); chk(irq, 1'b0);
		rd(`GPCFG_ADDR_INDATA, 8'h01);
		@(posedge clock); stop_mode <= 1'b0;
		pulse(16, 0);
		$display("test wake done");
		summarize;
	end
endmodule // test_gpio_pin_config_subregisters
